// ### core/fmds_fault_spi.sv
/*
 Fault supervision and daisy-chain serial slave: qualifies comparator
 faults, keeps the error register and interrupt, decodes 16-bit frames.
 Assumes raw comparator and serial pins asynchronous to clk, and an
 external wire resolving the open-drain fault line and the data out pin.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fmds_regs.svh"

module fmds_fault_spi #(
    parameter int TICK_CYCLES   = `FMDS_TICK_CYC,
    parameter int PERSIST_TICKS = `FMDS_PERSIST_TICKS
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       sclkPin,
    input  wire logic       dinPin,
    input  wire logic       chipSelectAN,
    input  wire logic       chipSelectBN,
    input  wire logic       overCurrentCmp,
    input  wire logic       nearRailCmp,
    input  wire logic       overTempCmp,
    input  wire logic       brownoutCmp,
    input  wire logic       variantAltPin,
    output var  logic       sdoOut,
    output var  logic       sdoOeN,
    output var  logic       readyN,
    output var  logic       faultOut,
    output var  logic       faultOeN,
    output var  logic       outputEnable,
    output var  logic       voltageMode,
    output var  logic [2:0] outputRange,
    output var  logic [3:0] brownoutSelect
);

    fmds_pkg::fmds_pins_t      pinsRaw;
    fmds_pkg::fmds_pins_t      pinsMeta_r;
    fmds_pkg::fmds_pins_t      pinsSync_r;
    fmds_pkg::fmds_pins_t      pinsPrev_r;
    fmds_pkg::fmds_cfg_t       cfg_r;
    fmds_pkg::fmds_spi_state_t state_r;
    logic [17:0] tickCnt_r;
    logic        tick_r;
    logic        selected;
    logic        sclkFall;
    logic [3:0]  bitCnt_r;
    logic [14:0] rxShift_r;
    logic [2:0]  cmd_r;
    logic [2:0]  cmdNow;
    logic [3:0]  nextIdx;
    logic [15:0] frameWord_r;
    logic [9:0]  rdWord;
    logic        frameDone_r;
    logic        sdoOut_r;
    logic        sdoOeN_r;
    logic        readyN_r;
    logic        faultOeN_r;
    logic        configured_r;
    logic        outputEnable_r;
    logic        errRead;
    logic        errReads_r;
    logic [9:0]  err_r;
    logic [9:0]  err_nxt;
    logic [9:0]  liveVec;
    logic        newSet;
    logic        shortCond;
    logic        openCond;
    logic        shortQ;
    logic        openQ;
    logic        otLock_r;
    logic [1:0]  otReads_r;
    logic        otNow;

    function automatic logic [9:0] readWord(
        input logic [2:0]          cmd,
        input fmds_pkg::fmds_cfg_t cfg,
        input logic [9:0]          err
    );
        case (cmd)
            `FMDS_CMD_RD_CFG: readWord = cfg;
            `FMDS_CMD_RD_ERR: readWord = err;
            default:          readWord = 10'h000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    assign pinsRaw = {sclkPin, dinPin, chipSelectAN, chipSelectBN,
                      overCurrentCmp, nearRailCmp, overTempCmp,
                      brownoutCmp, variantAltPin};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinsMeta_r <= `FMDS_PINS_IDLE;
            pinsSync_r <= `FMDS_PINS_IDLE;
            pinsPrev_r <= `FMDS_PINS_IDLE;
        end else begin
            pinsMeta_r <= pinsRaw;
            pinsSync_r <= pinsMeta_r;
            pinsPrev_r <= pinsSync_r;
        end
    end

    assign selected = !pinsSync_r.csAN && !pinsSync_r.csBN;
    assign sclkFall = pinsPrev_r.sclk && !pinsSync_r.sclk;

    ////////////////////////////////////////////////////////////////////////
    // Persistence timebase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tickCnt_r <= 18'h00000;
            tick_r    <= 1'b0;
        end else if (tickCnt_r == 18'(TICK_CYCLES - 1)) begin
            tickCnt_r <= 18'h00000;
            tick_r    <= 1'b1;
        end else begin
            tickCnt_r <= tickCnt_r + 18'h00001;
            tick_r    <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial frame receiver
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r     <= fmds_pkg::SPI_IDLE;
            bitCnt_r    <= 4'h0;
            rxShift_r   <= 15'h0000;
            cmd_r       <= `FMDS_CMD_NOP;
            frameDone_r <= 1'b0;
            frameWord_r <= 16'h0000;
        end else if (!selected) begin
            state_r     <= fmds_pkg::SPI_IDLE;
            bitCnt_r    <= 4'h0;
            frameDone_r <= 1'b0;
        end else begin
            frameDone_r <= 1'b0;
            case (state_r)
                fmds_pkg::SPI_IDLE: begin
                    state_r  <= fmds_pkg::SPI_SHIFT;
                    bitCnt_r <= 4'h0;
                end
                fmds_pkg::SPI_SHIFT: begin
                    if (sclkFall) begin
                        rxShift_r <= {rxShift_r[13:0], pinsSync_r.din};
                        bitCnt_r  <= bitCnt_r + 4'h1;
                        if (bitCnt_r == `FMDS_CMD_BIT) begin
                            cmd_r <= cmdNow;
                        end
                        if (bitCnt_r == `FMDS_LAST_BIT) begin
                            state_r     <= fmds_pkg::SPI_DONE;
                            frameDone_r <= 1'b1;
                            frameWord_r <= {rxShift_r, pinsSync_r.din};
                        end
                    end
                end
                fmds_pkg::SPI_DONE: begin
                    state_r <= fmds_pkg::SPI_DONE;
                end
                default: begin
                    state_r <= fmds_pkg::SPI_IDLE;
                end
            endcase
        end
    end

    assign cmdNow  = (bitCnt_r == `FMDS_CMD_BIT) ?
                     {rxShift_r[1:0], pinsSync_r.din} : cmd_r;
    assign nextIdx = `FMDS_NEXT_TOP - bitCnt_r;
    assign rdWord  = readWord(cmdNow, cfg_r, err_r);

    ////////////////////////////////////////////////////////////////////////
    // Data out and ready
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sdoOut_r <= 1'b0;
            sdoOeN_r <= 1'b1;
            readyN_r <= 1'b1;
        end else begin
            sdoOeN_r <= !(selected && state_r != fmds_pkg::SPI_DONE);
            readyN_r <= !(selected && state_r == fmds_pkg::SPI_DONE);
            if (!selected || state_r != fmds_pkg::SPI_SHIFT) begin
                sdoOut_r <= 1'b0;
            end else if (sclkFall) begin
                if (bitCnt_r >= `FMDS_CMD_BIT && bitCnt_r != `FMDS_LAST_BIT
                    && nextIdx <= `FMDS_DATA_TOP) begin
                    sdoOut_r <= rdWord[nextIdx];
                end else begin
                    sdoOut_r <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration and standby
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r        <= '0;
            configured_r <= 1'b0;
        end else if (frameDone_r &&
                     frameWord_r[13:11] == `FMDS_CMD_CONFIG) begin
            cfg_r        <= frameWord_r[9:0];
            configured_r <= 1'b1;
        end
    end

    assign otNow = pinsSync_r.overTemp;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            otLock_r  <= 1'b0;
            otReads_r <= 2'h0;
        end else begin
            if (cfg_r.otEnable && otNow) begin
                otLock_r <= 1'b1;
            end else if (otReads_r == `FMDS_OT_READS) begin
                otLock_r <= 1'b0;
            end
            if (otNow || otReads_r == `FMDS_OT_READS) begin
                otReads_r <= 2'h0;
            end else if (otLock_r && errRead) begin
                otReads_r <= otReads_r + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            outputEnable_r <= 1'b0;
        end else begin
            outputEnable_r <= configured_r && !otLock_r &&
                              !(cfg_r.otEnable && otNow);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault qualification
    always_comb begin
        if (pinsSync_r.variantAlt) begin
            shortCond = pinsSync_r.overCurrent && cfg_r.voltageMode;
            openCond  = pinsSync_r.nearRail;
        end else begin
            shortCond = pinsSync_r.overCurrent;
            openCond  = pinsSync_r.nearRail &&
                        !(pinsSync_r.overCurrent && !cfg_r.voltageMode);
        end
    end

    fmds_persist #(
        .PERSIST_TICKS (PERSIST_TICKS)
    ) u_shortPersist (
        .clk    (clk),
        .resetn (resetn),
        .tick   (tick_r),
        .cond   (shortCond),
        .qual   (shortQ)
    );

    fmds_persist #(
        .PERSIST_TICKS (PERSIST_TICKS)
    ) u_openPersist (
        .clk    (clk),
        .resetn (resetn),
        .tick   (tick_r),
        .cond   (openCond),
        .qual   (openQ)
    );

    always_comb begin
        liveVec = 10'h000;
        liveVec[`FMDS_ERR_SHORT] = shortQ &&
                                   (pinsSync_r.variantAlt || !openQ);
        liveVec[`FMDS_ERR_OPEN]  = openQ;
        liveVec[`FMDS_ERR_OTEMP] = otNow;
        liveVec[`FMDS_ERR_BROWN] = pinsSync_r.brownout;
    end

    ////////////////////////////////////////////////////////////////////////
    // Error register, read sequence and interrupt
    assign errRead = frameDone_r &&
                     frameWord_r[13:11] == `FMDS_CMD_RD_ERR;

    always_comb begin
        err_nxt = err_r;
        if (errRead && errReads_r) begin
            err_nxt = 10'h000;
        end
        err_nxt = err_nxt | liveVec;
        if (!errReads_r &&
            ((err_r[`FMDS_ERR_SHORT] && !liveVec[`FMDS_ERR_SHORT]) ||
             (err_r[`FMDS_ERR_OPEN] && !liveVec[`FMDS_ERR_OPEN]))) begin
            err_nxt[`FMDS_ERR_INTER] = 1'b1;
        end
    end

    assign newSet = |(err_nxt & ~err_r);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            err_r      <= 10'h000;
            errReads_r <= 1'b0;
        end else begin
            err_r <= err_nxt;
            if (newSet) begin
                errReads_r <= 1'b0;
            end else if (errRead) begin
                errReads_r <= !errReads_r;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            faultOeN_r <= 1'b1;
        end else if (newSet) begin
            faultOeN_r <= 1'b0;
        end else if (errRead && !errReads_r) begin
            faultOeN_r <= 1'b1;
        end
    end

    assign sdoOut         = sdoOut_r;
    assign sdoOeN         = sdoOeN_r;
    assign readyN         = readyN_r;
    assign faultOut       = 1'b0 & faultOeN_r;
    assign faultOeN       = faultOeN_r;
    assign outputEnable   = outputEnable_r;
    assign voltageMode    = cfg_r.voltageMode;
    assign outputRange    = cfg_r.outputRange;
    assign brownoutSelect = cfg_r.brownoutSel;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_port_deselect: assert property (@(posedge clk) disable iff (!resetn)
        !selected |=> sdoOeN_r && readyN_r)
        else $error("port active while a select is high");

    a_ready_after: assert property (@(posedge clk) disable iff (!resetn)
        frameDone_r && selected |=> !readyN_r)
        else $error("ready missing after full frame");

    a_irq_set: assert property (@(posedge clk) disable iff (!resetn)
        newSet |=> !faultOeN_r && (err_r & $past(liveVec)) == $past(liveVec))
        else $error("new error did not pull fault line");

    a_first_release: assert property (@(posedge clk) disable iff (!resetn)
        errRead && !errReads_r && !newSet |=> faultOeN_r
        && errReads_r && (err_r & $past(err_r)) == $past(err_r))
        else $error("first read mishandled");

    a_second_clear: assert property (@(posedge clk) disable iff (!resetn)
        errRead && errReads_r |=> err_r == $past(liveVec)
        && !errReads_r)
        else $error("second read did not clear");

    a_inter_source: assert property (@(posedge clk) disable iff (!resetn)
        $rose(err_r[`FMDS_ERR_INTER]) |->
        $past(err_r[`FMDS_ERR_SHORT] || err_r[`FMDS_ERR_OPEN]))
        else $error("intermittent bit from wrong source");

    a_ot_standby: assert property (@(posedge clk) disable iff (!resetn)
        otLock_r |=> !outputEnable_r)
        else $error("output enabled during overtemperature standby");

    a_ot_release: assert property (@(posedge clk) disable iff (!resetn)
        $fell(otLock_r) |-> $past(otReads_r) == `FMDS_OT_READS
        && !otNow)
        else $error("standby left without two reads");

    c_err_read:  cover property (@(posedge clk) disable iff (!resetn)
        errRead ##[1:1000] errRead);
    c_ot_lock:   cover property (@(posedge clk) disable iff (!resetn)
        $fell(otLock_r));
    c_intermit:  cover property (@(posedge clk) disable iff (!resetn)
        $rose(err_r[`FMDS_ERR_INTER]));

endmodule

`default_nettype wire

// ### core/fmds_regs.svh
/*
 Constants of the fault monitor with daisy-chain serial port: frame and
 command codes, error bit positions, pin reset levels, timebase counts.
 Assumes a 200 MHz core clock and a 1 ms persistence timebase tick.
*/
`ifndef FMDS_REGS_SVH
`define FMDS_REGS_SVH

`define FMDS_CMD_NOP      3'h0
`define FMDS_CMD_CONFIG   3'h1
`define FMDS_CMD_RD_CFG   3'h4
`define FMDS_CMD_RD_ERR   3'h5

`define FMDS_CMD_BIT      4'h4
`define FMDS_LAST_BIT     4'hf
`define FMDS_NEXT_TOP     4'he
`define FMDS_DATA_TOP     4'h9

`define FMDS_ERR_SHORT    0
`define FMDS_ERR_OPEN     1
`define FMDS_ERR_OTEMP    2
`define FMDS_ERR_BROWN    3
`define FMDS_ERR_INTER    9

`define FMDS_PINS_IDLE    9'h060
`define FMDS_OT_READS     2'h2

`define FMDS_CLK_MHZ      200
`define FMDS_TICK_US      1000
`define FMDS_TICK_CYC     (`FMDS_CLK_MHZ * `FMDS_TICK_US)
`define FMDS_TICK_MS      1
`define FMDS_PERSIST_MS   260
`define FMDS_PERSIST_TICKS (`FMDS_PERSIST_MS / `FMDS_TICK_MS + 1)

`endif

// ### core/fmds_pkg.sv
/*
 Types of the fault monitor: pin bundle, configuration word, port states.
 Assumes nothing beyond the constants header.
*/
package fmds_pkg;

    typedef struct packed {
        logic sclk;
        logic din;
        logic csAN;
        logic csBN;
        logic overCurrent;
        logic nearRail;
        logic overTemp;
        logic brownout;
        logic variantAlt;
    } fmds_pins_t;

    typedef struct packed {
        logic       reserved;
        logic       voltageMode;
        logic [2:0] outputRange;
        logic       otEnable;
        logic [3:0] brownoutSel;
    } fmds_cfg_t;

    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_SHIFT,
        SPI_DONE
    } fmds_spi_state_t;

endpackage

// ### core/fmds_persist.sv
/*
 Persistence qualifier: a condition must hold over a number of timebase
 ticks before the qualified output rises.
 Assumes a one-cycle tick and a condition on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module fmds_persist #(
    parameter int PERSIST_TICKS = 261
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic tick,
    input  wire logic cond,
    output var  logic qual
);

    logic [8:0] cnt_r;
    logic       qual_r;

    ////////////////////////////////////////////////////////////////////////
    // Tick counter, restarted whenever the condition drops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 9'h000;
        end else if (!cond) begin
            cnt_r <= 9'h000;
        end else if (tick && cnt_r != 9'(PERSIST_TICKS)) begin
            cnt_r <= cnt_r + 9'h001;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            qual_r <= 1'b0;
        end else begin
            qual_r <= cond && cnt_r == 9'(PERSIST_TICKS);
        end
    end

    assign qual = qual_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_persist_drop: assert property (@(posedge clk) disable iff (!resetn)
        !cond |=> !qual_r)
        else $error("qualified output survived a dropped condition");

    a_persist_full: assert property (@(posedge clk) disable iff (!resetn)
        $rose(qual_r) |-> $past(cnt_r) == 9'(PERSIST_TICKS))
        else $error("qualified output rose before full persistence");

endmodule

`default_nettype wire

// ### verification/fmds_host_model.sv
/*
 Host serial master model: drives both selects, clock and data of a frame.
 Assumes the bench resolves the data out line with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module fmds_host_model (
    input  wire logic clk,
    input  wire logic sdoLine,
    input  wire logic readyN,
    output var  logic sclk,
    output var  logic din,
    output var  logic csAN,
    output var  logic csBN
);
    initial begin
        sclk = 1'b0;
        din  = 1'b0;
        csAN = 1'b1;
        csBN = 1'b1;
    end

    // One frame of nBits clocks; holdB keeps the second select high
    task automatic xfer(input logic [15:0] w, input int nBits,
                        input logic holdB, output logic [9:0] rx,
                        output logic rdy);
        rx = 10'h000;
        @(posedge clk);
        #1;
        csAN = 1'b0;
        csBN = holdB;
        #36;
        for (int k = 1; k <= nBits; k++) begin
            #12 din = w[16-k];
            #12 sclk = 1'b1;
            #23;
            if (k >= 7 && k <= 16) rx[16-k] = sdoLine;
            #1 sclk = 1'b0;
        end
        for (int i = 0; i < 20 && readyN !== 1'b0; i++) @(posedge clk);
        rdy = (readyN === 1'b0);
        #24;
        din = ~din;
        @(posedge clk);
        #1;
        csAN = 1'b1;
        csBN = 1'b1;
        repeat (6) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// ### verification/tb_fmds_fault_spi.sv
/*
 Self-checking bench of the fault monitor: host model frames, comparator
 stimulus from a fixed-seed xorshift, expectations from bench functions.
 Assumes short timebase parameters and pull-ups on data out and fault.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_fmds_fault_spi;
    localparam int TICK = 10;
    localparam int PT   = 4;
    localparam int LONG = (PT + 3) * TICK + 20;
    logic        clk, resetn, oc, nr, ot, bo, alt, rdy;
    logic        sclk, din, csAN, csBN, sdoOut, sdoOeN, readyN;
    logic        faultOut, faultOeN, outEn, vMode, sdoLine, faultLine;
    logic [2:0]  oRange;
    logic [3:0]  boSel;
    logic [9:0]  rx, cfg;
    logic [31:0] seed = 32'h4f;
    logic [2:0]  codes [5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
    int          num_errors = 0;
    int          checks = 0;
    int          cycles = 0;

    assign sdoLine   = sdoOeN ? 1'b1 : sdoOut;
    assign faultLine = faultOeN ? 1'b1 : faultOut;

    fmds_fault_spi #(.TICK_CYCLES(TICK), .PERSIST_TICKS(PT)) i_dut (
        .clk(clk), .resetn(resetn), .sclkPin(sclk), .dinPin(din),
        .chipSelectAN(csAN), .chipSelectBN(csBN), .overCurrentCmp(oc),
        .nearRailCmp(nr), .overTempCmp(ot), .brownoutCmp(bo),
        .variantAltPin(alt), .sdoOut(sdoOut), .sdoOeN(sdoOeN),
        .readyN(readyN), .faultOut(faultOut), .faultOeN(faultOeN),
        .outputEnable(outEn), .voltageMode(vMode), .outputRange(oRange),
        .brownoutSelect(boSel)
    );

    fmds_host_model i_host (
        .clk(clk), .sdoLine(sdoLine), .readyN(readyN), .sclk(sclk),
        .din(din), .csAN(csAN), .csBN(csBN)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Expected {open, short} bits for a comparator pattern
    function automatic logic [9:0] expErr(input logic a, v, c, n);
        logic op;
        logic sh;
        op = a ? n : n & !(c & !v);
        sh = a ? c & v : c & !op;
        return {8'h00, op, sh};
    endfunction

    task automatic checkVal(input logic [9:0] got, exp, input string what);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic checkBit(input logic got, exp, input string what);
        checkVal({9'h000, got}, {9'h000, exp}, what);
    endtask

    task automatic frame(input logic [15:0] w, input int nb, input logic hb);
        i_host.xfer(w, nb, hb, rx, rdy);
        checkBit(rdy, nb == 16 && !hb, "ready");
        checkBit(readyN, 1'b1, "ready idle");
        checkBit(sdoOeN, 1'b1, "dout released");
    endtask

    task automatic rdErr();
        frame(16'h2800, 16, 1'b0);
    endtask

    task automatic setCfg(input logic [9:0] c);
        frame({6'h02, c}, 16, 1'b0);
    endtask

    task automatic apply(input logic a, c, n, t, b, input int len);
        @(posedge clk);
        #1;
        {alt, oc, nr, ot, bo} = {a, c, n, t, b};
        repeat (len) @(posedge clk);
    endtask

    task automatic clr(input int len);
        apply(alt, 1'b0, 1'b0, 1'b0, 1'b0, len);
    endtask

    task automatic endTest(input string name);
        $display("Test %s finished", name);
    endtask

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            $display("Error at %0t: run timed out", $time);
            complete_run();
        end
    end

    initial begin
        {resetn, oc, nr, ot, alt} = 5'h00;
        bo = 1'b1;
        repeat (12) @(posedge clk);
        #1;
        resetn = 1'b1;
        checkBit(outEn, 1'b0, "standby");
        checkVal({1'b0, vMode, oRange, 1'b0, boSel}, 10'h000, "cfg");
        repeat (6) @(posedge clk);
        clr(10);
        checkBit(faultLine, 1'b0, "power-up fault");
        rdErr();
        checkVal(rx, 10'h008, "read1");
        checkBit(faultLine, 1'b1, "release");
        rdErr();
        checkVal(rx, 10'h008, "read2");
        rdErr();
        checkVal(rx, 10'h000, "read3");
        endTest("power-up");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            cfg = {1'b0, seed[8:5], 1'b0, seed[3:0]};
            setCfg(cfg);
            frame(16'h2000, 16, 1'b0);
            checkVal(rx, cfg, "cfg readback");
            checkVal({1'b0, vMode, oRange, 1'b0, boSel}, cfg, "pins");
            checkBit(outEn, 1'b1, "configured");
        end
        foreach (codes[j]) begin
            seed = xs(seed);
            frame({2'h0, codes[j], seed[10:0]}, 16, 1'b0);
            frame(16'h2000, 16, 1'b0);
            checkVal(rx, cfg, "no effect");
        end
        frame({5'h01, 1'b0, ~cfg}, 16, 1'b1);
        frame({5'h01, 1'b0, ~cfg}, 8, 1'b0);
        frame(16'h2000, 16, 1'b0);
        checkVal(rx, cfg, "ignored frames");
        endTest("serial");
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            setCfg({1'b0, seed[1], 8'h00});
            apply(seed[0], seed[2], seed[3], 1'b0, 1'b0, 2 * TICK);
            clr(3);
            apply(seed[0], seed[2], seed[3], 1'b0, 1'b0, 2 * TICK);
            clr(6);
            checkBit(faultLine, 1'b1, "short pulses");
            cfg = expErr(seed[0], seed[1], seed[2], seed[3]);
            apply(seed[0], seed[2], seed[3], 1'b0, 1'b0, LONG);
            checkBit(faultLine, cfg == 10'h000, "fault");
            rdErr();
            checkVal(rx, cfg, "qualified");
            checkBit(faultLine, 1'b1, "release");
            clr(6);
            rdErr();
            rdErr();
            checkVal(rx, 10'h000, "cleared");
        end
        endTest("qualify");
        setCfg(10'h000);
        apply(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, LONG);
        clr(6);
        rdErr();
        checkVal(rx, 10'h202, "intermittent");
        rdErr();
        rdErr();
        checkVal(rx, 10'h000, "cleared");
        apply(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, LONG);
        clr(6);
        rdErr();
        checkVal(rx, 10'h008, "no intermittent");
        apply(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, LONG);
        checkBit(faultLine, 1'b0, "new fault");
        clr(6);
        rdErr();
        rdErr();
        rdErr();
        checkVal(rx, 10'h000, "cleared");
        endTest("intermittent");
        setCfg(10'h010);
        apply(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, LONG);
        checkBit(outEn, 1'b0, "standby hot");
        rdErr();
        checkVal(rx, 10'h004, "hot flag");
        rdErr();
        clr(6);
        checkBit(outEn, 1'b0, "still standby");
        rdErr();
        rdErr();
        checkBit(outEn, 1'b1, "resumed");
        endTest("overtemp");
        complete_run();
    end
endmodule

`default_nettype wire
